// ---- rtl/tba_pkg.sv ----
// Package of constants and types for the two-wire bus arbiter
package tba_pkg;
   // Gray-coded arbitration states along reset -> external -> implicit -> explicit
   typedef enum logic [1:0] {
      TBA_ST_RESET = 2'b00,
      TBA_ST_EXT_MASTER = 2'b01,
      TBA_ST_IMPLICIT = 2'b11,
      TBA_ST_EXPLICIT = 2'b10
   } tba_state_t;
   localparam logic [1:0] TBA_SYNC_STAGES = 2'h2;
   localparam logic TBA_BUS_DRIVEN_N_RESET = 1'h1;
endpackage

// ---- rtl/tba_sync.sv ----
// Two-flop synchroniser for a single level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module tba_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule
`default_nettype wire

// ---- rtl/tba_arbiter.sv ----
// Two-wire bus arbitration state machine of the external bus
// What the document requires of this block and of the external master
// RULE1: Device may start a transfer the cycle after grant is seen asserted.
// RULE2: External master asserts grant only after it stopped driving the bus.
// RULE3: External master never grants while its own transfer is in progress.
// RULE4: Lock clear, grant negated: finish cycle, negate bus-driven, three-state outputs.
// RULE5: Burst-inhibited access keeps bus-driven asserted until its last transfer completes.
// RULE6: Lock set in explicit ownership: grant negation does not release the bus.
// RULE7: While lock set, mastership is held regardless of grant.
// RULE8: Lock cleared with grant negated: bus-driven negated next clock, bus released.
// RULE9: Granted with a request pending: bus-driven asserted next clock, access begins.
// RULE10: Reset pin or watchdog reset forces reset state from any state.
// RULE11: Leaving reset: implicit ownership if granted, else external-master ownership.
// RULE12: External-master ownership: bus not driven, bus-driven negated, memory controls allowed.
// RULE13: Implicit ownership: bus three-stated until request or lock moves to explicit.
// RULE14: Explicit ownership when granted and cycle started or lock set; drives bus.
// RULE15: With grant asserted, explicit ownership holds whether or not cycles run.
// RULE16: Grant negated, lock clear: leave explicit at end of cycle or at once.
// RULE17: End of cycle is normal or error termination; burst-inhibited series counts once.
// RULE18: External ownership: stay while ungranted; granted goes explicit or implicit.
// RULE19: State changes only on the rising edge of the system clock.
// RULE20: Active-low grant from hold request; active-low bus-driven feeds hold acknowledge.
`timescale 1ns/1ps
`default_nettype none
module tba_arbiter (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reset_input_pin_n,
   input wire logic watchdog_reset,
   input wire logic bus_grant_in_n,
   input wire logic bus_lock_flag,
   input wire logic int_bus_request,
   input wire logic transfer_in_progress,
   input wire logic end_of_cycle,
   input wire logic burst_inhibit_last,
   output logic bus_driven_out_n,
   output logic bus_drive_en,
   output logic bus_owned,
   output logic start_allowed,
   output logic external_master_owner_state,
   output tba_pkg::tba_state_t arb_state
);
   import tba_pkg::*;

   // ***************************************************
   // Pin synchronisers
   // ***************************************************
   logic grant_n_s;
   logic rst_pin_n_s;
   logic grant;
   logic any_reset;
   logic cycle_done;

   // RULE20 grant pin is active low, idles negated
   tba_sync #(.RESET_VAL(1'b1)) u_sync_grant (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_in(bus_grant_in_n),
      .sync_out(grant_n_s)
   );

   tba_sync #(.RESET_VAL(1'b0)) u_sync_reset_input_pin (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_in(reset_input_pin_n),
      .sync_out(rst_pin_n_s)
   );

   assign grant = ~grant_n_s;
   assign any_reset = ~rst_pin_n_s | watchdog_reset;
   // RULE17 only the last transfer of a burst-inhibited series ends the cycle
   assign cycle_done = end_of_cycle & burst_inhibit_last;

   // ***************************************************
   // Arbitration state machine
   // ***************************************************
   tba_state_t state_q;
   tba_state_t state_d;

   always_comb begin
      state_d = state_q;
      // RULE10 reset from any state
      if (any_reset) begin
         state_d = TBA_ST_RESET;
      end else begin
         unique case (state_q)
            // RULE11 grant picks the exit
            TBA_ST_RESET: begin
               state_d = grant ? TBA_ST_IMPLICIT : TBA_ST_EXT_MASTER;
            end
            // RULE18 wait for grant then choose ownership
            // RULE9 pending request goes explicit
            TBA_ST_EXT_MASTER: begin
               if (grant) begin
                  state_d = (bus_lock_flag | int_bus_request) ? TBA_ST_EXPLICIT
                                                               : TBA_ST_IMPLICIT;
               end
            end
            // RULE13 request or lock moves to explicit
            TBA_ST_IMPLICIT: begin
               if (!grant) begin
                  state_d = TBA_ST_EXT_MASTER;
               end else if (bus_lock_flag | int_bus_request) begin
                  state_d = TBA_ST_EXPLICIT;
               end
            end
            // RULE16 release only with lock clear and cycle over
            // RULE6 RULE7 lock keeps ownership
            TBA_ST_EXPLICIT: begin
               if (!grant && !bus_lock_flag) begin
                  // RULE4 RULE5 finish cycle first
                  // RULE8 unlocked and ungranted releases
                  // Lock is tested at the releasing edge itself, so a late lock still holds
                  if (!transfer_in_progress || cycle_done) begin
                     state_d = TBA_ST_EXT_MASTER;
                  end
               end
            end
         endcase
      end
   end

   // RULE19 state registered on the rising edge only
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= TBA_ST_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // ***************************************************
   // Outputs
   // ***************************************************
   logic bd_n_q;
   logic bd_n_d;

   // RULE14 bus-driven asserted exactly in explicit ownership
   always_comb begin
      bd_n_d = (state_d == TBA_ST_EXPLICIT) ? 1'b0 : TBA_BUS_DRIVEN_N_RESET;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bd_n_q <= TBA_BUS_DRIVEN_N_RESET;
      end else begin
         bd_n_q <= bd_n_d;
      end
   end

   assign bus_driven_out_n = bd_n_q;
   // RULE12 only explicit ownership drives address, data and control
   assign bus_drive_en = ~bd_n_q;
   assign bus_owned = (state_q == TBA_ST_IMPLICIT) | (state_q == TBA_ST_EXPLICIT);
   // RULE1 transfer may start once explicit ownership is held
   assign start_allowed = (state_q == TBA_ST_EXPLICIT);
   assign external_master_owner_state = (state_q == TBA_ST_EXT_MASTER);
   assign arb_state = state_q;

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   bd_matches_state_a: assert property (bus_driven_out_n == (state_q != TBA_ST_EXPLICIT)) // RULE14
      else $error("bus-driven does not match explicit state");
   reset_forces_state_a: assert property (any_reset |=> state_q == TBA_ST_RESET) // RULE10
      else $error("reset did not force reset state");
   reset_exit_a: assert property ((state_q == TBA_ST_RESET && !any_reset)
      |=> state_q == (grant ? TBA_ST_IMPLICIT : TBA_ST_EXT_MASTER)) // RULE11
      else $error("wrong exit from reset state");
   lock_holds_bus_a: assert property ((state_q == TBA_ST_EXPLICIT && bus_lock_flag && !any_reset)
      |=> !bus_driven_out_n) // RULE7
      else $error("bus released while locked");
   grant_request_a: assert property ((state_q == TBA_ST_EXT_MASTER && grant && int_bus_request
      && !any_reset) |=> !bus_driven_out_n) // RULE9
      else $error("granted request did not assert bus-driven");
   unlock_release_a: assert property ((state_q == TBA_ST_EXPLICIT && !grant && !bus_lock_flag
      && !transfer_in_progress && !any_reset) |=> bus_driven_out_n) // RULE8
      else $error("bus not released after unlock");
   burst_hold_a: assert property ((state_q == TBA_ST_EXPLICIT && transfer_in_progress
      && !cycle_done && !any_reset) |=> !bus_driven_out_n) // RULE5
      else $error("bus released mid burst-inhibited access");
   granted_stays_a: assert property ((state_q == TBA_ST_EXPLICIT && grant && !any_reset)
      |=> state_q == TBA_ST_EXPLICIT) // RULE15
      else $error("explicit ownership lost while granted");
   implicit_idle_a: assert property ((state_q == TBA_ST_IMPLICIT && grant && !bus_lock_flag
      && !int_bus_request && !any_reset) |=> state_q == TBA_ST_IMPLICIT) // RULE13
      else $error("implicit ownership left without cause");
   ext_idle_a: assert property ((state_q == TBA_ST_EXT_MASTER && !grant && !any_reset)
      |=> state_q == TBA_ST_EXT_MASTER) // RULE18
      else $error("external ownership left without grant");

   ext_no_drive_a: assert property ((state_q == TBA_ST_EXT_MASTER)
      |-> (bus_driven_out_n && !bus_drive_en)) // RULE12
      else $error("bus driven in external ownership");
   implicit_no_drive_a: assert property ((state_q == TBA_ST_IMPLICIT)
      |-> (bus_driven_out_n && !bus_drive_en)) // RULE13
      else $error("bus driven in implicit ownership");
   drive_follows_bd_a: assert property (bus_drive_en == !bus_driven_out_n) // RULE4
      else $error("bus drivers disagree with bus-driven");
   lock_ungranted_a: assert property ((state_q == TBA_ST_EXPLICIT && !grant && bus_lock_flag
      && !any_reset) |=> state_q == TBA_ST_EXPLICIT) // RULE6
      else $error("locked ownership left on grant negation");
   burst_release_a: assert property ((state_q == TBA_ST_EXPLICIT && !grant && !bus_lock_flag
      && transfer_in_progress && cycle_done && !any_reset)
      |=> state_q == TBA_ST_EXT_MASTER) // RULE16
      else $error("bus kept after last transfer ended");
   implicit_request_a: assert property ((state_q == TBA_ST_IMPLICIT && grant && int_bus_request
      && !any_reset) |=> !bus_driven_out_n) // RULE9
      else $error("request in implicit ownership not served");

   implicit_to_explicit_c: cover property (state_q == TBA_ST_IMPLICIT
      ##1 state_q == TBA_ST_EXPLICIT);
   locked_ungranted_c: cover property (state_q == TBA_ST_EXPLICIT && !grant && bus_lock_flag);
   release_c: cover property (state_q == TBA_ST_EXPLICIT ##1 state_q == TBA_ST_EXT_MASTER);
   burst_end_c: cover property (state_q == TBA_ST_EXPLICIT && transfer_in_progress
      && cycle_done && !grant);
   watchdog_c: cover property (state_q == TBA_ST_EXPLICIT && watchdog_reset
      ##1 state_q == TBA_ST_RESET);
endmodule
`default_nettype wire

// ---- verif/tba_ext_master.sv ----
// External bus master model that shares the bus through hold request and acknowledge
`timescale 1ns/1ps
`default_nettype none
module tba_ext_master (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ext_need,
   input wire logic bus_driven_out_n,
   output logic bus_grant_in_n
);
   logic hold_req_q;
   logic own_busy_q;
   assign bus_grant_in_n = hold_req_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hold_req_q <= 1'h1;
         own_busy_q <= 1'h0;
      end else begin
         // Own transfer runs only while the device acknowledges the hold
         own_busy_q <= hold_req_q & bus_driven_out_n & ext_need;
         hold_req_q <= ext_need | own_busy_q;
      end
   end
endmodule
`default_nettype wire

// ---- verif/two_wire_bus_arbitration_tb_top.sv ----
// Self-checking bench for the two-wire bus arbiter
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_arbitration_tb_top;
   import tba_pkg::*;
   logic clk_sys = 1'h0;
   logic rst = 1'h1;
   logic reset_input_pin_n = 1'h0;
   logic watchdog_reset = 1'h0;
   logic ext_need = 1'h1;
   logic bus_lock_flag = 1'h0;
   logic int_bus_request = 1'h0;
   logic transfer_in_progress = 1'h0;
   logic end_of_cycle = 1'h0;
   logic burst_inhibit_last = 1'h1;
   logic bus_grant_in_n, bus_driven_out_n, bus_drive_en, bus_owned;
   logic start_allowed, external_master_owner_state;
   tba_state_t arb_state;
   int err_count = 0;
   int compares = 0;
   always #12.5 clk_sys = ~clk_sys;
   tba_arbiter i_tba_arbiter (.clk_sys, .rst, .reset_input_pin_n, .watchdog_reset,
      .bus_grant_in_n, .bus_lock_flag, .int_bus_request, .transfer_in_progress,
      .end_of_cycle, .burst_inhibit_last, .bus_driven_out_n, .bus_drive_en, .bus_owned,
      .start_allowed, .external_master_owner_state, .arb_state);
   tba_ext_master i_tba_ext_master (.clk_sys, .rst, .ext_need, .bus_driven_out_n,
      .bus_grant_in_n);
   // ****************************************
   // Checking helpers
   // ****************************************
   task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Outputs per state, driving and ownership follow the state table
   function automatic logic [6:0] exp_v(input tba_state_t s);
      logic bd;
      bd = (s == TBA_ST_EXPLICIT);
      return {s, ~bd, bd, s[1], bd, s == TBA_ST_EXT_MASTER};
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic see(input tba_state_t s);
      #1;
      chk({arb_state, bus_driven_out_n, bus_drive_en, bus_owned, start_allowed,
         external_master_owner_state}, exp_v(s));
      @(posedge clk_sys);
   endtask
   // Old state holds until the edge n cycles after the drive, new state from then
   task automatic lat(input int n, input tba_state_t s_old, input tba_state_t s_new);
      step(n - 1);
      see(s_old);
      see(s_new);
   endtask
   task automatic stop_test();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      step(20);
      rst <= 1'h0;
      reset_input_pin_n <= 1'h1;
      lat(3, TBA_ST_RESET, TBA_ST_EXT_MASTER);
      ext_need <= 1'h0;
      lat(5, TBA_ST_EXT_MASTER, TBA_ST_IMPLICIT);
      bus_lock_flag <= 1'h1;
      lat(1, TBA_ST_IMPLICIT, TBA_ST_EXPLICIT);
      bus_lock_flag <= 1'h0;
      step(2);
      see(TBA_ST_EXPLICIT);
      ext_need <= 1'h1;
      lat(4, TBA_ST_EXPLICIT, TBA_ST_EXT_MASTER);
      int_bus_request <= 1'h1;
      ext_need <= 1'h0;
      lat(5, TBA_ST_EXT_MASTER, TBA_ST_EXPLICIT);
      transfer_in_progress <= 1'h1;
      burst_inhibit_last <= 1'h0;
      ext_need <= 1'h1;
      step(6);
      see(TBA_ST_EXPLICIT);
      end_of_cycle <= 1'h1;
      step(1);
      see(TBA_ST_EXPLICIT);
      burst_inhibit_last <= 1'h1;
      lat(1, TBA_ST_EXPLICIT, TBA_ST_EXT_MASTER);
      end_of_cycle <= 1'h0;
      transfer_in_progress <= 1'h0;
      int_bus_request <= 1'h0;
      bus_lock_flag <= 1'h1;
      ext_need <= 1'h0;
      lat(5, TBA_ST_EXT_MASTER, TBA_ST_EXPLICIT);
      ext_need <= 1'h1;
      step(8);
      see(TBA_ST_EXPLICIT);
      bus_lock_flag <= 1'h0;
      lat(1, TBA_ST_EXPLICIT, TBA_ST_EXT_MASTER);
      ext_need <= 1'h0;
      int_bus_request <= 1'h1;
      lat(5, TBA_ST_EXT_MASTER, TBA_ST_EXPLICIT);
      watchdog_reset <= 1'h1;
      lat(1, TBA_ST_EXPLICIT, TBA_ST_RESET);
      watchdog_reset <= 1'h0;
      lat(1, TBA_ST_RESET, TBA_ST_IMPLICIT);
      see(TBA_ST_EXPLICIT);
      reset_input_pin_n <= 1'h0;
      lat(3, TBA_ST_EXPLICIT, TBA_ST_RESET);
      stop_test();
   end
   // Whole run is near 90 cycles, so this only trips on a hang
   initial begin
      step(2000);
      err_count++;
      stop_test();
   end
endmodule
`default_nettype wire
